// ===== src/page_access_check.sv
// Combinational protection check of one reference against a descriptor.
// Assumes the caller samples the result on its own timing strobe.
`timescale 1ns/100ps
`default_nettype none
module page_access_check (
  // Descriptor and reference
  input wire page_protection_pkg::descriptor_type desc_i,
  input wire logic [6:0] block_number_i,
  input wire logic is_write_i,
  // Outcome
  output page_protection_pkg::check_result_type result_o
);
  import page_protection_pkg::*;

  logic length_error;
  logic key_abort;

  // Length check depends on growth direction
  always_comb begin
    if (desc_i.expansion_direction) begin
      length_error = block_number_i < desc_i.page_length_limit;
    end else begin
      length_error = block_number_i > desc_i.page_length_limit;
    end
  end

  // Abort dominates; a trap alone lets the reference finish
  always_comb begin
    key_abort = key_aborts(desc_i.access_key_field, is_write_i);
    result_o.abort = key_abort || length_error;
    result_o.trap = !result_o.abort &&
                    key_traps(desc_i.access_key_field, is_write_i);
  end

endmodule : page_access_check
`default_nettype wire

// ===== src/page_descriptor_protection.sv
// Page descriptor store with protection check and history flag upkeep.
// Assumes timing strobes t4/t5 and cycle flags come from processor logic
// on ref_clk_i; base registers and address decode live elsewhere.
`timescale 1ns/100ps
`default_nettype none
module page_descriptor_protection #(
  parameter int unsigned DESC_COUNT = 16,
  localparam int unsigned IDX_W = $clog2(DESC_COUNT)
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Processor timing
  input wire logic t4_i,
  input wire logic t5_i,
  input wire logic bus_start_cycle_i,
  input wire logic pause_cycle_i,
  input wire logic relocation_enabled_i,
  // Relocated reference
  input wire logic [IDX_W-1:0] relocation_enabled_index_i,
  input wire logic [15:0] virt_addr_i,
  input wire logic write_cycle_indicator_i,
  // Program access to descriptors and base registers
  input wire logic register_access_select_i,
  input wire logic [IDX_W-1:0] prog_index_i,
  input wire logic desc_write_i,
  input wire logic base_write_i,
  input wire logic desc_read_i,
  input wire logic [15:0] prog_wdata_i,
  // Results to the processor
  output logic abort_condition_o,
  output logic trap_condition_o,
  output logic check_valid_o,
  output logic [15:0] prog_rdata_o
);
  import page_protection_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Descriptor storage
  //
  // One word per page. Only the loadable fields and the two history
  // flags carry meaning; the reserved bits are masked on the way in and
  // read back as zero, so software cannot park private data in them and
  // later find it changed by a flag write-back.

  descriptor_type page_descriptor [DESC_COUNT];
  descriptor_type relocation_enabled_desc;
  check_result_type check_now;
  logic [6:0] block_number;

  logic mem_we;
  logic [IDX_W-1:0] mem_widx;
  descriptor_type mem_wdata;

  // Descriptor read in step with the base register for relocation
  always_comb begin
    relocation_enabled_desc = page_descriptor[relocation_enabled_index_i];
    block_number = virt_addr_i[VA_BN_MSB:VA_BN_LSB];
  end

  // Check runs every cycle; sampled only at bus-start T5
  // Free running keeps the compare off the strobe's own timing path
  page_access_check page_access_check_inst (
    .desc_i(relocation_enabled_desc),
    .block_number_i(block_number),
    .is_write_i(write_cycle_indicator_i),
    .result_o(check_now)
  );

  ////////////////////////////////////////////////////////////////////////
  // History flag sequencing
  //
  // The old flags are saved at bus-start T5 and the new ones go back at
  // pause T4: one read-modify-write spread over two processor cycles.

  // Phase of the sequence
  flag_phase_type phase;
  flag_phase_type next_phase;
  // Old flags and the reference they belong to
  logic accessed_history_latch;
  logic next_accessed_history_latch;
  logic written_history_latch;
  logic next_written_history_latch;
  logic [IDX_W-1:0] held_index;
  logic [IDX_W-1:0] next_held_index;
  logic held_write;
  logic next_held_write;
  // Check results
  logic abort_condition;
  logic next_abort_condition;
  logic trap_condition;
  logic next_trap_condition;
  logic next_check_valid;
  // Qualified strobes
  logic flag_writeback_enable;
  logic bus_start_cycle_t5;
  logic pause_t4;

  // Strobe qualification; a pause T4 counts only while a check is held,
  // so a stray strobe never writes flags of a page that was not checked
  always_comb begin
    bus_start_cycle_t5 = bus_start_cycle_i && t5_i;
    pause_t4 = pause_cycle_i && t4_i && (phase == HELD);
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase of the read-modify-write
  //
  // Only one reference can be held at a time. A second bus-start T5
  // before the pause simply replaces the held copy, since the processor
  // abandoned the first reference and its flags must not be written.

  // Next phase; a fresh bus-start without a pause restarts the sequence
  always_comb begin
    next_phase = phase;
    unique case (phase)
      IDLE: begin
        if (bus_start_cycle_t5) begin
          next_phase = HELD;
        end
      end
      HELD: begin
        if (pause_t4 && !bus_start_cycle_t5) begin
          next_phase = IDLE;
        end
      end
    endcase
    next_check_valid = (next_phase == HELD);
  end

  // Register the phase and its copy seen by the processor
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      phase <= IDLE;
      check_valid_o <= 1'b0;
    end else begin
      phase <= next_phase;
      check_valid_o <= next_check_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Holding flops for the old flags and the reference
  //
  // The index and the write indicator are held as well: the processor
  // may already present the next address and cycle type before the
  // pause T4 of this reference arrives.

  // Save old flags before this reference can change them
  always_comb begin
    next_accessed_history_latch = accessed_history_latch;
    next_written_history_latch = written_history_latch;
    next_held_index = held_index;
    next_held_write = held_write;
    if (bus_start_cycle_t5) begin
      next_accessed_history_latch = relocation_enabled_desc.accessed;
      next_written_history_latch = relocation_enabled_desc.written;
      next_held_index = relocation_enabled_index_i;
      next_held_write = write_cycle_indicator_i;
    end
  end

  // Register the held copy
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      accessed_history_latch <= 1'b0;
      written_history_latch <= 1'b0;
      held_index <= '0;
      held_write <= 1'b0;
    end else begin
      accessed_history_latch <= next_accessed_history_latch;
      written_history_latch <= next_written_history_latch;
      held_index <= next_held_index;
      held_write <= next_held_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Check results
  //
  // Results are taken once per reference and then stand until the next
  // bus-start T5; the processor reads them in the pause cycle, well
  // before its data phase ends, and can still suppress an abort.

  // Unrelocated references are never checked
  always_comb begin
    next_abort_condition = abort_condition;
    next_trap_condition = trap_condition;
    if (bus_start_cycle_t5) begin
      next_abort_condition = relocation_enabled_i && check_now.abort;
      next_trap_condition = relocation_enabled_i && check_now.trap;
    end
  end

  // Register the results
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      abort_condition <= 1'b0;
      trap_condition <= 1'b0;
    end else begin
      abort_condition <= next_abort_condition;
      trap_condition <= next_trap_condition;
    end
  end

  // Results leave straight from flops, ready by the pause cycle
  always_comb begin
    abort_condition_o = abort_condition;
    trap_condition_o = trap_condition;
  end

  ////////////////////////////////////////////////////////////////////////
  // Single write port into the descriptor store
  //
  // Program loads and the flag write-back share one port. The write-back
  // is blocked while the program selects any descriptor or base register,
  // so a load never loses its clear to a set in the same cycle. A load
  // made between T5 and T4 with the select already dropped is overwritten
  // by the held flags; software must not reload a page in mid-reference.

  descriptor_type wb_desc;

  // Both kinds of program load wipe the history of their descriptor
  function automatic descriptor_type history_cleared(
    input descriptor_type desc
  );
    history_cleared = desc;
    history_cleared.accessed = 1'b0;
    history_cleared.written = 1'b0;
  endfunction : history_cleared

  // New flags for the held descriptor; an abort leaves both clear
  always_comb begin
    wb_desc = page_descriptor[held_index];
    wb_desc.accessed = !abort_condition &&
                       (trap_condition || accessed_history_latch);
    wb_desc.written = !abort_condition &&
                      (held_write || written_history_latch);
  end

  // Program access and flag write-back are exclusive by the select
  always_comb begin
    flag_writeback_enable = pause_t4 && relocation_enabled_i &&
                            !register_access_select_i;
    mem_we = 1'b0;
    mem_widx = held_index;
    mem_wdata = wb_desc;
    if (register_access_select_i && desc_write_i) begin
      // Loadable fields only; both flags forced clear
      mem_we = 1'b1;
      mem_widx = prog_index_i;
      mem_wdata = history_cleared(
        descriptor_type'(prog_wdata_i & WRITABLE_MASK));
    end else if (register_access_select_i && base_write_i) begin
      // Base load invalidates history of its descriptor
      mem_we = 1'b1;
      mem_widx = prog_index_i;
      mem_wdata = history_cleared(page_descriptor[prog_index_i]);
    end else if (flag_writeback_enable) begin
      mem_we = 1'b1;
    end
  end

  // Store update; reset leaves every page non-resident
  // Key 000 everywhere makes a reference made before software loads the
  // descriptors abort instead of reaching an arbitrary frame
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DESC_COUNT; i++) begin
        page_descriptor[i] <= descriptor_type'(DESC_RESET);
      end
    end else if (mem_we) begin
      page_descriptor[mem_widx] <= mem_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program read-back
  //
  // Read data is a registered copy so it stands while the processor
  // finishes its cycle. A read and a flag write-back never share an
  // edge, since the select that a read needs blocks the write-back.

  logic [15:0] next_prog_rdata;

  // Reserved bits read as zero; data holds until the next read
  always_comb begin
    next_prog_rdata = prog_rdata_o;
    if (register_access_select_i && desc_read_i) begin
      next_prog_rdata = page_descriptor[prog_index_i] & READ_MASK;
    end
  end

  // Register the read data
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      prog_rdata_o <= 16'h0000;
    end else begin
      prog_rdata_o <= next_prog_rdata;
    end
  end

endmodule : page_descriptor_protection
`default_nettype wire

// ===== src/page_protection_pkg.sv
// Constants, field layout and types for page descriptor protection.
// Assumes one processor clock; timing strobes arrive from the same domain.
// Behaviour
// - Descriptor bits 2:0 hold access key
// - Keys 000/011/111 abort; 001/010 abort writes
// - Keys 100/101/110 allow writes; trap as keyed
// - Abort suppresses reference; trap lets it complete
// - Any word-modifying cycle counts as write
// - Bit 7 set when trap condition met
// - Bit 6 set when page was written
// - Program descriptor/base write clears both flags
// - Latch old flags at T5 of bus-start
// - Write flags back at T4 of pause
// - New accessed flag: no abort, trap or old
// - New written flag: no abort, write or old
// - Bit 3 picks upward or downward growth
// - Length field 14:8 against address bits 12:6
// - Length error aborts, per growth direction
// - Descriptor read alongside base during relocation
package page_protection_pkg;

  // Field positions within a descriptor word
  localparam int unsigned KEY_LSB = 0;
  localparam int unsigned ED_BIT = 3;
  localparam int unsigned WRITTEN_BIT = 6;
  localparam int unsigned ACCESSED_BIT = 7;
  localparam int unsigned PLF_LSB = 8;
  localparam int unsigned PLF_MSB = 14;
  // Block number bits in the virtual address
  localparam int unsigned VA_BN_LSB = 6;
  localparam int unsigned VA_BN_MSB = 12;
  // Program-loadable bits: length, direction, key
  localparam logic [15:0] WRITABLE_MASK = 16'h7f0f;
  // Readable bits: loadable bits plus the two history flags
  localparam logic [15:0] READ_MASK = 16'h7fcf;
  localparam logic [15:0] DESC_RESET = 16'h0000;

  // Access key encodings
  localparam logic [2:0] KEY_NONRES = 3'h0;
  localparam logic [2:0] KEY_RO_TRAP = 3'h1;
  localparam logic [2:0] KEY_RO = 3'h2;
  localparam logic [2:0] KEY_RSV_A = 3'h3;
  localparam logic [2:0] KEY_RW_TRAP = 3'h4;
  localparam logic [2:0] KEY_RW_TRAPW = 3'h5;
  localparam logic [2:0] KEY_RW = 3'h6;
  localparam logic [2:0] KEY_RSV_B = 3'h7;

  // Descriptor word as stored
  typedef struct packed {
    logic rsv15;
    logic [6:0] page_length_limit;
    logic accessed;
    logic written;
    logic [1:0] rsv5_4;
    logic expansion_direction;
    logic [2:0] access_key_field;
  } descriptor_type;

  // Outcome of one protection check
  typedef struct packed {
    logic abort;
    logic trap;
  } check_result_type;

  // Sequencing of the read-modify-write of the history flags
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    HELD = 2'b01
  } flag_phase_type;

  // Key decides abort for this access direction
  function automatic logic key_aborts(input logic [2:0] key,
                                      input logic is_write);
    unique case (key)
      KEY_RO_TRAP, KEY_RO: key_aborts = is_write;
      KEY_RW_TRAP, KEY_RW_TRAPW, KEY_RW: key_aborts = 1'b0;
      default: key_aborts = 1'b1;
    endcase
  endfunction : key_aborts

  // Key decides trap for this access direction
  function automatic logic key_traps(input logic [2:0] key,
                                     input logic is_write);
    unique case (key)
      KEY_RO_TRAP: key_traps = !is_write;
      KEY_RW_TRAP: key_traps = 1'b1;
      KEY_RW_TRAPW: key_traps = is_write;
      default: key_traps = 1'b0;
    endcase
  endfunction : key_traps

endpackage : page_protection_pkg

// ===== tb/cpu_timing_model.sv
// Processor timing model: one bus-start cycle with T5, then a pause with T4.
// Assumes the bench raises go_i by non-blocking assignment at a falling edge.
`timescale 1ns/100ps
`default_nettype none
module cpu_timing_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Request from the bench
  input wire logic go_i,
  // Timing to the block
  output logic bus_start_cycle_o,
  output logic t5_o,
  output logic pause_cycle_o,
  output logic t4_o
);
  logic [2:0] step;
  // Steps on falling edges so the block samples settled strobes
  always @(negedge ref_clk_i) begin
    if (rst_i)
      step <= 3'h0;
    else if (step != 3'h0 || go_i)
      step <= (step == 3'h4) ? 3'h0 : step + 3'h1;
  end
  // Bus-start spans two cycles; T5 in the first, T4 in the pause
  assign bus_start_cycle_o = (step == 3'h1) || (step == 3'h2);
  assign t5_o = step == 3'h1;
  assign pause_cycle_o = step == 3'h3;
  assign t4_o = step == 3'h3;
endmodule : cpu_timing_model
`default_nettype wire

// ===== tb/page_descriptor_protection_bench.sv
// Self-checking bench for page descriptor protection.
// Assumes the timing model and the checker compile before this file.
`timescale 1ns/100ps
`default_nettype none
module page_descriptor_protection_bench;
  import page_protection_pkg::*;
  localparam logic [7:0] ABORT_ALL = 8'h89;
  localparam logic [7:0] ABORT_WR = 8'h06;
  localparam logic [7:0] TRAP_RD = 8'h12;
  localparam logic [7:0] TRAP_WR = 8'h30;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic t4_i, t5_i, bus_start_cycle_i, pause_cycle_i;
  logic relocation_enabled_i = 1'b0;
  logic write_cycle_indicator_i = 1'b0;
  logic register_access_select_i = 1'b0;
  logic desc_write_i = 1'b0;
  logic base_write_i = 1'b0;
  logic desc_read_i = 1'b0;
  logic [3:0] relocation_enabled_index_i = 4'h0;
  logic [3:0] prog_index_i = 4'h0;
  logic [15:0] virt_addr_i = 16'h0000;
  logic [15:0] prog_wdata_i = 16'h0000;
  logic abort_condition_o, trap_condition_o, check_valid_o;
  logic [15:0] prog_rdata_o;
  logic ab, tr, a, t;
  logic [15:0] d;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock, block under test and processor timing
  always #5 ref_clk_i = !ref_clk_i;
  page_descriptor_protection page_descriptor_protection_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .t4_i(t4_i), .t5_i(t5_i),
    .bus_start_cycle_i(bus_start_cycle_i), .pause_cycle_i(pause_cycle_i),
    .relocation_enabled_i(relocation_enabled_i),
    .relocation_enabled_index_i(relocation_enabled_index_i), .virt_addr_i(virt_addr_i),
    .write_cycle_indicator_i(write_cycle_indicator_i),
    .register_access_select_i(register_access_select_i),
    .prog_index_i(prog_index_i), .desc_write_i(desc_write_i),
    .base_write_i(base_write_i), .desc_read_i(desc_read_i),
    .prog_wdata_i(prog_wdata_i), .abort_condition_o(abort_condition_o),
    .trap_condition_o(trap_condition_o), .check_valid_o(check_valid_o),
    .prog_rdata_o(prog_rdata_o));
  cpu_timing_model cpu_timing_model_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .go_i(go),
    .bus_start_cycle_o(bus_start_cycle_i), .t5_o(t5_i),
    .pause_cycle_o(pause_cycle_i), .t4_o(t4_i));
  ////////////////////////////////////////////////////////////////////////
  // Compare and count; verdict in one place
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  // Program write of descriptor or base register, select given
  task automatic prog(input logic [3:0] i, input logic [15:0] w,
                      input logic base, input logic sel);
    @(negedge ref_clk_i);
    register_access_select_i <= sel;
    prog_index_i <= i;
    prog_wdata_i <= w;
    desc_write_i <= !base;
    base_write_i <= base;
    @(negedge ref_clk_i);
    register_access_select_i <= 1'b0;
    desc_write_i <= 1'b0;
    base_write_i <= 1'b0;
  endtask : prog
  // Program read, compared a cycle after the read is taken
  task automatic rd(input logic [3:0] i, input logic [15:0] exp);
    @(negedge ref_clk_i);
    register_access_select_i <= 1'b1;
    prog_index_i <= i;
    desc_read_i <= 1'b1;
    @(negedge ref_clk_i);
    register_access_select_i <= 1'b0;
    desc_read_i <= 1'b0;
    @(negedge ref_clk_i);
    chk(prog_rdata_o, exp);
  endtask : rd
  // One relocated reference; select may be held over the pause
  task automatic access(input logic [3:0] i, input logic [6:0] bn,
                        input logic wr, input logic rel, input logic sel);
    @(negedge ref_clk_i);
    relocation_enabled_index_i <= i;
    virt_addr_i <= {3'h0, bn, 6'h15};
    write_cycle_indicator_i <= wr;
    relocation_enabled_i <= rel;
    register_access_select_i <= sel;
    go <= 1'b1;
    @(negedge ref_clk_i);
    go <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    ab = abort_condition_o;
    tr = trap_condition_o;
    chk({15'h0, check_valid_o}, 16'h0001);
    repeat (2) @(negedge ref_clk_i);
    chk({15'h0, check_valid_o}, 16'h0000);
    register_access_select_i <= 1'b0;
  endtask : access
  // Hang guard
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(negedge ref_clk_i);
    rst_i <= 1'b0;
    rd(4'h3, 16'h0000);
    prog(4'h3, 16'hffff, 1'b0, 1'b1);
    rd(4'h3, 16'h7f0f);
    // Every key, read and write, flags after write-back
    for (int k = 0; k < 8; k++) begin
      for (int w = 0; w < 2; w++) begin
        d = 16'h7f00 | 16'(k);
        prog(4'(k), d, 1'b0, 1'b1);
        access(4'(k), 7'h7f, w[0], 1'b1, 1'b0);
        a = ABORT_ALL[k] | (w[0] & ABORT_WR[k]);
        t = !a & (w[0] ? TRAP_WR[k] : TRAP_RD[k]);
        chk({15'h0, ab}, {15'h0, a});
        chk({15'h0, tr}, {15'h0, t});
        rd(4'(k), d | {8'h0, t, !a & w[0], 6'h0});
      end
    end
    // History upkeep on one descriptor, key 110, limit 0a upward
    prog(4'h9, 16'h0a06, 1'b0, 1'b1);
    access(4'h9, 7'h0a, 1'b1, 1'b1, 1'b0);
    chk({15'h0, ab}, 16'h0000);
    rd(4'h9, 16'h0a46);
    access(4'h9, 7'h05, 1'b0, 1'b1, 1'b0);
    rd(4'h9, 16'h0a46);
    access(4'h9, 7'h7f, 1'b1, 1'b0, 1'b0);
    chk({15'h0, ab}, 16'h0000);
    rd(4'h9, 16'h0a46);
    access(4'h9, 7'h0b, 1'b0, 1'b1, 1'b0);
    chk({15'h0, ab}, 16'h0001);
    rd(4'h9, 16'h0a06);
    access(4'h9, 7'h00, 1'b1, 1'b1, 1'b1);
    rd(4'h9, 16'h0a06);
    access(4'h9, 7'h00, 1'b1, 1'b1, 1'b0);
    prog(4'h9, 16'h0000, 1'b1, 1'b1);
    rd(4'h9, 16'h0a06);
    prog(4'h9, 16'h0000, 1'b0, 1'b0);
    rd(4'h9, 16'h0a06);
    // Boundaries for 52 octal blocks up and down
    for (int n = 0; n < 4; n++) begin
      d = (n < 2) ? 16'h2906 : 16'h560e;
      prog(4'ha, d, 1'b0, 1'b1);
      access(4'ha, n[1] ? 7'h56 - 7'(n[0]) : 7'h29 + 7'(n[0]),
             1'b0, 1'b1, 1'b0);
      chk({15'h0, ab}, {15'h0, n[0]});
    end
    stop_test();
  end
endmodule : page_descriptor_protection_bench
bind page_descriptor_protection page_protection_properties
  page_protection_properties_inst (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .t4_i(t4_i), .t5_i(t5_i),
  .bus_start_cycle_i(bus_start_cycle_i), .pause_cycle_i(pause_cycle_i),
  .relocation_enabled_i(relocation_enabled_i),
  .register_access_select_i(register_access_select_i),
  .desc_read_i(desc_read_i), .abort_condition_o(abort_condition_o),
  .trap_condition_o(trap_condition_o), .check_valid_o(check_valid_o),
  .prog_rdata_o(prog_rdata_o));
`default_nettype wire

// ===== tb/page_protection_properties.sv
// Checker for the page descriptor protection results and read port.
// Bound to the top module; sees its ports only, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module page_protection_properties (
  // Clock, reset and timing
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic t4_i,
  input wire logic t5_i,
  input wire logic bus_start_cycle_i,
  input wire logic pause_cycle_i,
  input wire logic relocation_enabled_i,
  // Program access
  input wire logic register_access_select_i,
  input wire logic desc_read_i,
  // Results
  input wire logic abort_condition_o,
  input wire logic trap_condition_o,
  input wire logic check_valid_o,
  input wire logic [15:0] prog_rdata_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  // Steps of the history flag read-modify-write
  sequence s_latch;
    bus_start_cycle_i && t5_i;
  endsequence
  sequence s_back;
    check_valid_o && pause_cycle_i && t4_i && !bus_start_cycle_i;
  endsequence
  chk_latch_valid: assert property (s_latch |=> check_valid_o)
    else $error("check_valid not raised after bus-start T5");
  chk_back_clear: assert property (s_back |=> !check_valid_o)
    else $error("check_valid not dropped after pause T4");
  chk_valid_holds: assert property (
    check_valid_o && !(pause_cycle_i && t4_i) |=> check_valid_o)
    else $error("check_valid dropped without pause T4");
  chk_valid_cause: assert property ($rose(check_valid_o) |->
    $past(t5_i) && $past(bus_start_cycle_i))
    else $error("check_valid rose without bus-start T5");
  chk_off_quiet: assert property (s_latch ##0 !relocation_enabled_i |=>
    !abort_condition_o && !trap_condition_o)
    else $error("result raised with relocation off");
  chk_abort_no_trap: assert property (
    abort_condition_o |-> !trap_condition_o)
    else $error("trap shown together with abort");
  chk_result_stands: assert property (!(bus_start_cycle_i && t5_i) |=>
    $stable(abort_condition_o) && $stable(trap_condition_o))
    else $error("result changed between checks");
  chk_rdata_hold: assert property (
    !(register_access_select_i && desc_read_i) |=> $stable(prog_rdata_o))
    else $error("read data changed without a read");
  chk_rdata_zero: assert property (
    (prog_rdata_o & 16'h8030) == 16'h0000)
    else $error("unused descriptor bits read nonzero");
endmodule : page_protection_properties
`default_nettype wire
